// file: ssr_pkg.sv
// Shared constants, register map and types of the supply reset supervisor
package ssr_pkg;

   // Time base
   localparam int unsigned CLK_MHZ        = 125;

   // Reset hold period options, microseconds as printed (1.4 ms, 30 ms, 200 ms, 1.6 s)
   localparam int unsigned HOLD_SHORT_US  = 1400;
   localparam int unsigned HOLD_MID_US    = 30000;
   localparam int unsigned HOLD_STD_US    = 200000;
   localparam int unsigned HOLD_LONG_US   = 1600000;
   localparam int unsigned HOLD_SHORT_CYC = HOLD_SHORT_US * CLK_MHZ;
   localparam int unsigned HOLD_MID_CYC   = HOLD_MID_US * CLK_MHZ;
   localparam int unsigned HOLD_STD_CYC   = HOLD_STD_US * CLK_MHZ;
   localparam int unsigned HOLD_LONG_CYC  = HOLD_LONG_US * CLK_MHZ;

   // Watchdog period, microseconds (1.6 s standard)
   localparam int unsigned WD_STD_US      = 1600000;
   localparam int unsigned WD_STD_CYC     = WD_STD_US * CLK_MHZ;

   // Manual input glitch filter, nanoseconds; a least time, so rounded up
   localparam int unsigned MAN_FILT_NS    = 100;
   localparam int unsigned MAN_FILT_CYC   = (MAN_FILT_NS * CLK_MHZ + 999) / 1000;

   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_STATUS     = 8'h04;
   localparam logic [7:0]  OFS_CAUSE      = 8'h08;

   // Control fields
   localparam int unsigned CTRL_HOLD_LSB  = 0;
   localparam logic [1:0]  HOLD_SEL_SHORT = 2'h0;
   localparam logic [1:0]  HOLD_SEL_MID   = 2'h1;
   localparam logic [1:0]  HOLD_SEL_STD   = 2'h2;
   localparam logic [1:0]  HOLD_SEL_LONG  = 2'h3;
   localparam logic [1:0]  CTRL_RESET     = HOLD_SEL_STD;

   // Status fields
   localparam int unsigned STAT_RST_LSB   = 0;
   localparam int unsigned STAT_WDEN_LSB  = 1;
   localparam int unsigned STAT_SUPOK_LSB = 2;
   localparam int unsigned STAT_MAN_LSB   = 3;
   localparam int unsigned STAT_STATE_LSB = 4;

   // Cause fields, sticky, write one to clear
   localparam int unsigned CAUSE_PWR      = 0;
   localparam int unsigned CAUSE_SUPPLY   = 1;
   localparam int unsigned CAUSE_MANUAL   = 2;
   localparam int unsigned CAUSE_WDOG     = 3;
   localparam logic [3:0]  CAUSE_RESET    = 4'h1;

   // Output driver variants of the active-low reset pin
   typedef enum logic [1:0] {
      SSR_OD_EXT = 2'h0,
      SSR_OD_INT = 2'h1,
      SSR_PUSH   = 2'h2
   } ssr_drive_e;

   // Sequencer states
   typedef enum logic [2:0] {
      SSR_ST_ASSERT = 3'h1,
      SSR_ST_HOLD   = 3'h2,
      SSR_ST_RUN    = 3'h4
   } ssr_state_e;

endpackage : ssr_pkg

// file: ssr_supervisor.sv
// Reset sequencer of the supply supervisor with AHB-Lite register slave
`timescale 1ns/1ps

module ssr_supervisor #(
   parameter ssr_pkg::ssr_drive_e DRIVE          = ssr_pkg::SSR_PUSH,
   parameter int unsigned         HOLD_SHORT_CYC = ssr_pkg::HOLD_SHORT_CYC,
   parameter int unsigned         HOLD_MID_CYC   = ssr_pkg::HOLD_MID_CYC,
   parameter int unsigned         HOLD_STD_CYC   = ssr_pkg::HOLD_STD_CYC,
   parameter int unsigned         HOLD_LONG_CYC  = ssr_pkg::HOLD_LONG_CYC,
   parameter int unsigned         WD_CYC         = ssr_pkg::WD_STD_CYC
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        below_trip_async,
   input  wire logic        above_hys_async,
   input  wire logic        manual_push_input_n,
   input  wire logic        watchdog_kick_input,
   output logic             rst_n_out,
   output logic             rst_n_oe,
   output logic             rst_n_pullup_en,
   output logic             rst_hi_out
);

   localparam int unsigned MF_W = $clog2(ssr_pkg::MAN_FILT_CYC + 1);
   localparam logic [MF_W-1:0] MF_TOP = MF_W'(ssr_pkg::MAN_FILT_CYC);

   // Hold period in cycles for a select code
   function automatic logic [31:0] hold_cycles(input logic [1:0] sel);
      logic [31:0] c;
      c = HOLD_STD_CYC;
      unique case (sel)
         ssr_pkg::HOLD_SEL_SHORT: c = HOLD_SHORT_CYC;
         ssr_pkg::HOLD_SEL_MID:   c = HOLD_MID_CYC;
         ssr_pkg::HOLD_SEL_STD:   c = HOLD_STD_CYC;
         ssr_pkg::HOLD_SEL_LONG:  c = HOLD_LONG_CYC;
      endcase
      return c;
   endfunction : hold_cycles

   // Input synchronisers: {watchdog, manual_n, above_hys, below_trip}
   logic [3:0] sync1_reg, sync1_next;
   logic [3:0] sync2_reg, sync2_next;
   logic       below_s, above_s, man_s, wd_s;

   always_comb begin
      sync1_next = {watchdog_kick_input, manual_push_input_n, above_hys_async, below_trip_async};
      sync2_next = sync1_reg;
   end

   // Manual and kick inputs idle high; matching the kick edge detector avoids a false edge
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sync1_reg <= 4'hc;
         sync2_reg <= 4'hc;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   assign below_s = sync2_reg[0];
   assign above_s = sync2_reg[1];
   assign man_s   = sync2_reg[2];
   assign wd_s    = sync2_reg[3];

   // Supply state with hysteresis; the threshold lives in the comparator, fixed at build
   logic supply_ok_reg, supply_ok_next;

   always_comb begin
      supply_ok_next = supply_ok_reg;
      if (below_s) begin
         supply_ok_next = 1'b0;
      end else if (above_s) begin
         supply_ok_next = 1'b1;
      end
   end

   // Starts bad: at power-up the supply has not yet proven itself
   always_ff @(posedge clk) begin
      if (!nrst) begin
         supply_ok_reg <= 1'b0;
      end else begin
         supply_ok_reg <= supply_ok_next;
      end
   end

   // Manual glitch filter: low must stand the filter time before it counts
   logic [MF_W-1:0] man_cnt_reg, man_cnt_next;
   logic            man_low_reg, man_low_next;

   always_comb begin
      man_cnt_next = man_cnt_reg;
      if (man_s) begin
         man_cnt_next = '0;
      end else if (man_cnt_reg != MF_TOP) begin
         man_cnt_next = man_cnt_reg + 1'b1;
      end
      man_low_next = (man_cnt_next == MF_TOP);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         man_cnt_reg <= '0;
         man_low_reg <= 1'b0;
      end else begin
         man_cnt_reg <= man_cnt_next;
         man_low_reg <= man_low_next;
      end
   end

   // Watchdog; disarmed while reset is active so a rebooting host re-arms it
   ssr_pkg::ssr_state_e state_reg, state_next;
   logic        rst_act;
   logic        wd_prev_reg, wd_prev_next;
   logic        wd_en_reg, wd_en_next;
   logic [31:0] wd_cnt_reg, wd_cnt_next;
   logic        wd_fall, wd_edge, wd_to;

   assign rst_act = (state_reg != ssr_pkg::SSR_ST_RUN);
   assign wd_fall = wd_prev_reg & ~wd_s;
   assign wd_edge = wd_prev_reg ^ wd_s;

   always_comb begin
      wd_prev_next = wd_s;
      wd_en_next   = wd_en_reg;
      wd_cnt_next  = wd_cnt_reg;
      wd_to        = 1'b0;
      if (rst_act) begin
         wd_en_next  = 1'b0;
         wd_cnt_next = '0;
      end else if (!wd_en_reg) begin
         if (wd_fall) begin
            wd_en_next  = 1'b1;
            wd_cnt_next = '0;
         end
      end else if (wd_edge) begin
         wd_cnt_next = '0;
      end else if (wd_cnt_reg == WD_CYC - 1) begin
         wd_to       = 1'b1;
         wd_cnt_next = '0;
      end else begin
         wd_cnt_next = wd_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wd_prev_reg <= 1'b1;
         wd_en_reg   <= 1'b0;
         wd_cnt_reg  <= '0;
      end else begin
         wd_prev_reg <= wd_prev_next;
         wd_en_reg   <= wd_en_next;
         wd_cnt_reg  <= wd_cnt_next;
      end
   end

   // Reset sequencer: any cause asserts, hold timer releases
   logic [1:0]  ctrl_hold_reg, ctrl_hold_next;
   logic [31:0] hold_cnt_reg, hold_cnt_next;
   logic [31:0] hold_tgt;
   logic        cause_any;

   assign cause_any = ~supply_ok_reg | man_low_reg | wd_to;
   assign hold_tgt  = hold_cycles(ctrl_hold_reg);

   always_comb begin
      state_next    = state_reg;
      hold_cnt_next = hold_cnt_reg;
      unique case (state_reg)
         ssr_pkg::SSR_ST_ASSERT: begin
            hold_cnt_next = '0;
            if (!cause_any) begin
               state_next = ssr_pkg::SSR_ST_HOLD;
            end
         end
         ssr_pkg::SSR_ST_HOLD: begin
            if (cause_any) begin
               state_next    = ssr_pkg::SSR_ST_ASSERT;
               hold_cnt_next = '0;
            end else if (hold_cnt_reg >= hold_tgt - 1) begin
               state_next = ssr_pkg::SSR_ST_RUN;
            end else begin
               hold_cnt_next = hold_cnt_reg + 32'h1;
            end
         end
         ssr_pkg::SSR_ST_RUN: begin
            if (cause_any) begin
               state_next = ssr_pkg::SSR_ST_ASSERT;
            end
         end
         default: begin
            state_next = ssr_pkg::SSR_ST_ASSERT;
         end
      endcase
   end

   // Reset itself is the power-up cause: the sequencer starts asserting
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg    <= ssr_pkg::SSR_ST_ASSERT;
         hold_cnt_reg <= '0;
      end else begin
         state_reg    <= state_next;
         hold_cnt_reg <= hold_cnt_next;
      end
   end

   // Pin drivers, registered from the next state so they track it exactly
   logic rst_n_out_reg, rst_n_out_next;
   logic rst_n_oe_reg, rst_n_oe_next;
   logic rst_n_pu_reg, rst_n_pu_next;
   logic rst_hi_reg, rst_hi_next;
   logic act_next;

   always_comb begin
      act_next       = (state_next != ssr_pkg::SSR_ST_RUN);
      rst_hi_next    = act_next;
      rst_n_out_next = 1'b0;
      rst_n_oe_next  = act_next;
      rst_n_pu_next  = 1'b0;
      unique case (DRIVE)
         ssr_pkg::SSR_PUSH: begin
            rst_n_out_next = ~act_next;
            rst_n_oe_next  = 1'b1;
         end
         ssr_pkg::SSR_OD_INT: begin
            rst_n_pu_next = ~act_next;
         end
         ssr_pkg::SSR_OD_EXT: begin
            rst_n_pu_next = 1'b0;
         end
         default: begin
            rst_n_oe_next = act_next;
         end
      endcase
   end

   // Resistor is cut while the pin pulls low, saving supply current
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rst_n_out_reg <= 1'b0;
         rst_n_oe_reg  <= 1'b1;
         rst_n_pu_reg  <= 1'b0;
         rst_hi_reg    <= 1'b1;
      end else begin
         rst_n_out_reg <= rst_n_out_next;
         rst_n_oe_reg  <= rst_n_oe_next;
         rst_n_pu_reg  <= rst_n_pu_next;
         rst_hi_reg    <= rst_hi_next;
      end
   end

   assign rst_n_out       = rst_n_out_reg;
   assign rst_n_oe        = rst_n_oe_reg;
   assign rst_n_pullup_en = rst_n_pu_reg;
   assign rst_hi_out      = rst_hi_reg;

   // AHB-Lite slave, zero wait states; read data built from next values to see a prior write
   logic        dp_valid_reg, dp_valid_next;
   logic        dp_write_reg, dp_write_next;
   logic [7:0]  dp_addr_reg, dp_addr_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic [3:0]  cause_reg, cause_next;
   logic [3:0]  cause_set, cause_clr;
   logic [31:0] status_word;
   logic        ap_take, dp_wr;

   assign ap_take   = hsel & hready & htrans[1];
   assign dp_wr     = dp_valid_reg & dp_write_reg;
   assign cause_set = {wd_to, man_low_reg, ~supply_ok_reg, 1'b0};

   always_comb begin
      dp_valid_next  = ap_take;
      dp_write_next  = ap_take & hwrite;
      dp_addr_next   = haddr[7:0];
      ctrl_hold_next = ctrl_hold_reg;
      cause_clr      = 4'h0;
      if (dp_wr && dp_addr_reg == ssr_pkg::OFS_CTRL) begin
         ctrl_hold_next = hwdata[ssr_pkg::CTRL_HOLD_LSB +: 2];
      end
      if (dp_wr && dp_addr_reg == ssr_pkg::OFS_CAUSE) begin
         cause_clr = hwdata[3:0];
      end
      // Set wins over a clear in the same cycle
      cause_next  = (cause_reg & ~cause_clr) | cause_set;
      status_word = '0;
      status_word[ssr_pkg::STAT_RST_LSB]        = (state_next != ssr_pkg::SSR_ST_RUN);
      status_word[ssr_pkg::STAT_WDEN_LSB]       = wd_en_next;
      status_word[ssr_pkg::STAT_SUPOK_LSB]      = supply_ok_next;
      status_word[ssr_pkg::STAT_MAN_LSB]        = man_low_next;
      status_word[ssr_pkg::STAT_STATE_LSB +: 3] = state_next;
      hrdata_next = hrdata_reg;
      if (ap_take && !hwrite) begin
         unique case (haddr[7:0])
            ssr_pkg::OFS_CTRL:   hrdata_next = {30'h0, ctrl_hold_next};
            ssr_pkg::OFS_STATUS: hrdata_next = status_word;
            ssr_pkg::OFS_CAUSE:  hrdata_next = {28'h0, cause_next};
            default:             hrdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dp_valid_reg  <= 1'b0;
         dp_write_reg  <= 1'b0;
         dp_addr_reg   <= 8'h00;
         hrdata_reg    <= 32'h0;
         ctrl_hold_reg <= ssr_pkg::CTRL_RESET;
         cause_reg     <= ssr_pkg::CAUSE_RESET;
      end else begin
         dp_valid_reg  <= dp_valid_next;
         dp_write_reg  <= dp_write_next;
         dp_addr_reg   <= dp_addr_next;
         hrdata_reg    <= hrdata_next;
         ctrl_hold_reg <= ctrl_hold_next;
         cause_reg     <= cause_next;
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_supply_lost;
      !supply_ok_reg;
   endsequence

   sequence s_hold_done;
      state_reg == ssr_pkg::SSR_ST_HOLD && !cause_any && hold_cnt_reg >= hold_tgt - 1;
   endsequence

   a_supply_low_reset: assert property (s_supply_lost |=> rst_hi_out && state_reg == ssr_pkg::SSR_ST_ASSERT)
      else $error("reset not active while supply low");
   a_hold_full_time: assert property ($rose(state_reg == ssr_pkg::SSR_ST_RUN) |-> $past(hold_cnt_reg) >= $past(hold_tgt) - 1)
      else $error("reset released before hold period");
   a_release_pins: assert property (s_hold_done |=> !rst_hi_out ##0 (rst_n_out || !rst_n_oe))
      else $error("pins not released after hold");
   a_od_ext_float: assert property (DRIVE == ssr_pkg::SSR_OD_EXT && !rst_hi_out |-> !rst_n_oe && !rst_n_pullup_en)
      else $error("external pull-up pin not floating");
   a_od_int_pullup: assert property (DRIVE == ssr_pkg::SSR_OD_INT |-> rst_n_pullup_en == !rst_n_oe)
      else $error("internal pull-up not matching drive");
   a_push_pull_low: assert property (DRIVE == ssr_pkg::SSR_PUSH |-> rst_n_oe && rst_n_out == !rst_hi_out)
      else $error("push-pull pin not complementary");
   a_hyst_keep: assert property (supply_ok_reg && !below_s |=> supply_ok_reg)
      else $error("supply state dropped without trip");
   a_man_filter: assert property ($rose(man_low_reg) |-> $past(!man_s, 1) && $past(man_cnt_reg) == MF_TOP - 1)
      else $error("manual low taken before filter time");
   a_man_forces: assert property (man_low_reg |=> state_reg == ssr_pkg::SSR_ST_ASSERT)
      else $error("filtered manual low did not assert reset");
   a_wd_timeout: assert property (wd_to |-> wd_en_reg && wd_cnt_reg == WD_CYC - 1 ##1 rst_hi_out)
      else $error("watchdog timeout wrong");
   a_wd_idle: assert property (!wd_en_reg && !wd_fall |=> !wd_en_reg)
      else $error("watchdog armed without falling edge");
   a_wd_restart: assert property (wd_en_reg && wd_edge && !rst_act |=> wd_cnt_reg == 32'h0)
      else $error("watchdog edge did not restart count");

endmodule : ssr_supervisor

// file: ssr_host_model.sv
// Host controller model that kicks the watchdog input of the supervisor
`timescale 1ns/1ps

module ssr_host_model (
   input  wire logic       clk,
   input  wire logic       rst_level_n,
   input  wire logic       kick_en,
   input  wire logic [7:0] half_period,
   output logic            kick
);
   int cnt;

   // Idles high so the first toggle is a falling edge
   initial begin
      kick = 1'b1;
      cnt = 0;
   end

   // A host held in reset runs no code, so it stops kicking
   always @(posedge clk) begin
      if (kick_en && rst_level_n === 1'b1) begin
         if (cnt >= int'(half_period) - 1) begin
            kick <= ~kick;
            cnt <= 0;
         end else begin
            cnt <= cnt + 1;
         end
      end else begin
         cnt <= 0;
      end
   end
endmodule : ssr_host_model

// file: supply_reset_supervisor_tb.sv
// Self-checking testbench of the supply reset supervisor
`timescale 1ns/1ps

module supply_reset_supervisor_tb;
   logic        clk, nrst, hsel, hwrite, below, above, manual_n, kick_en, kick;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  half;
   logic        hready, hresp, rd_pend;
   logic        pp_hi, pp_oe, pp_out, pp_pu, oi_hi, oi_oe, oi_out, oi_pu, ox_hi, ox_oe, ox_out, ox_pu;
   logic        lvl_pp, lvl_oi, lvl_ox;
   logic [31:0] exp_q[$];
   int          bad_count, compares, cycles;
   int          holds[4] = '{20, 30, 50, 80};

   // Pin levels; the internal pull-up only acts when enabled, the bare open-drain pin floats
   assign lvl_pp = pp_oe ? pp_out : 1'bz;
   assign lvl_oi = oi_oe ? oi_out : (oi_pu ? 1'b1 : 1'bz);
   assign lvl_ox = ox_oe ? ox_out : 1'bz;

   // Three driver variants share all inputs; only the push-pull one answers the bus
   ssr_supervisor #(.DRIVE(ssr_pkg::SSR_PUSH), .HOLD_SHORT_CYC(20), .HOLD_MID_CYC(30), .HOLD_STD_CYC(50),
      .HOLD_LONG_CYC(80), .WD_CYC(100)) u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .below_trip_async(below), .above_hys_async(above),
      .manual_push_input_n(manual_n), .watchdog_kick_input(kick), .rst_n_out(pp_out), .rst_n_oe(pp_oe),
      .rst_n_pullup_en(pp_pu), .rst_hi_out(pp_hi));
   ssr_supervisor #(.DRIVE(ssr_pkg::SSR_OD_INT), .HOLD_SHORT_CYC(20), .HOLD_MID_CYC(30), .HOLD_STD_CYC(50),
      .HOLD_LONG_CYC(80), .WD_CYC(100)) u_dut_odi (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(),
      .hreadyout(), .hresp(), .below_trip_async(below), .above_hys_async(above),
      .manual_push_input_n(manual_n), .watchdog_kick_input(kick), .rst_n_out(oi_out), .rst_n_oe(oi_oe),
      .rst_n_pullup_en(oi_pu), .rst_hi_out(oi_hi));
   ssr_supervisor #(.DRIVE(ssr_pkg::SSR_OD_EXT), .HOLD_SHORT_CYC(20), .HOLD_MID_CYC(30), .HOLD_STD_CYC(50),
      .HOLD_LONG_CYC(80), .WD_CYC(100)) u_dut_odx (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(),
      .hreadyout(), .hresp(), .below_trip_async(below), .above_hys_async(above),
      .manual_push_input_n(manual_n), .watchdog_kick_input(kick), .rst_n_out(ox_out), .rst_n_oe(ox_oe),
      .rst_n_pullup_en(ox_pu), .rst_hi_out(ox_hi));

   ssr_host_model u_host (.clk(clk), .rst_level_n(lvl_pp), .kick_en(kick_en), .half_period(half),
      .kick(kick));

   // 125 MHz
   initial clk = 1'b0;
   always #4 clk = ~clk;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task end_of_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   // Cuts a hang short; the run needs well under 10000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   // Read data are taken at the edge that ends the data phase
   always @(posedge clk) begin
      if (rd_pend) begin
         if (exp_q.size() == 0) bad_count++;
         else chk("read data", exp_q.pop_front(), hrdata);
      end
      rd_pend <= hsel && hready && htrans[1] && !hwrite;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // One single AHB-Lite word transfer; a read notes its expected data
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00, a};
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hsize <= 3'($urandom());
      hwdata <= wr ? d : 32'h0;
      if (!wr) exp_q.push_back(d);
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
   endtask : ahb

   task automatic chk_pins(input logic act);
      chk("push pins", act ? 32'hc : 32'h6, {28'h0, pp_hi, pp_oe, lvl_pp, pp_pu});
      chk("od int pins", act ? 32'hc : 32'h3, {28'h0, oi_hi, oi_oe, lvl_oi, oi_pu});
      chk("od ext pins", act ? 32'hc : {28'h0, 4'b00z0}, {28'h0, ox_hi, ox_oe, lvl_ox, ox_pu});
   endtask : chk_pins

   // Counts edges from the end of the last cause until the outputs release
   task automatic wait_rel(input int hold, input int slack);
      int n;
      n = 0;
      while (pp_hi !== 1'b0 && n < 2000) begin
         cyc(1);
         n++;
      end
      chk("hold length", 32'h1, {31'h0, (n >= hold && n <= hold + slack)});
      chk_pins(1'b0);
   endtask : wait_rel

   initial begin
      int g;
      logic [31:0] w;
      {nrst, hsel, hwrite, manual_n, kick_en, rd_pend} = 6'b000100;
      {haddr, hwdata, htrans, hsize} = {32'h0, 32'h0, 2'h0, 3'h2};
      {below, above, half} = {1'b1, 1'b0, 8'h1e};
      {bad_count, compares, cycles} = {32'h0, 32'h0, 32'h0};
      w = $urandom(32'hbada);
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      cyc(1);
      chk_pins(1'b1);
      ahb(0, ssr_pkg::OFS_CTRL, {30'h0, ssr_pkg::CTRL_RESET});
      // Power-up bit from reset, supply bit set while the supply is still low
      ahb(0, ssr_pkg::OFS_CAUSE, 32'h3);
      ahb(0, ssr_pkg::OFS_STATUS, 32'h11);
      ahb(0, 8'h0c, 32'h0);
      cyc(40);
      chk_pins(1'b1);
      @(posedge clk);
      {below, above} <= 2'b01;
      wait_rel(holds[2], 7);
      ahb(1, ssr_pkg::OFS_STATUS, 32'hffffffff);
      ahb(1, 8'h0c, 32'hffffffff);
      ahb(0, ssr_pkg::OFS_STATUS, 32'h44);
      ahb(1, ssr_pkg::OFS_CAUSE, 32'hf);
      // Supply dip, then a stay between the two thresholds
      @(posedge clk);
      {below, above} <= 2'b10;
      cyc(6);
      chk_pins(1'b1);
      @(posedge clk);
      below <= 1'b0;
      cyc(200);
      chk_pins(1'b1);
      @(posedge clk);
      above <= 1'b1;
      wait_rel(holds[2], 7);
      ahb(0, ssr_pkg::OFS_CAUSE, 32'h2);
      ahb(1, ssr_pkg::OFS_CAUSE, 32'hf);
      // Each hold option with a rejected glitch and a real press
      for (int sel = 0; sel < 4; sel++) begin
         w = $urandom();
         ahb(1, ssr_pkg::OFS_CTRL, {w[31:2], sel[1:0]});
         ahb(0, ssr_pkg::OFS_CTRL, {30'h0, sel[1:0]});
         g = 1 + $urandom_range(11);
         @(posedge clk);
         manual_n <= 1'b0;
         repeat (g) @(posedge clk);
         manual_n <= 1'b1;
         cyc(20);
         chk_pins(1'b0);
         @(posedge clk);
         manual_n <= 1'b0;
         cyc(18 + $urandom_range(15));
         chk_pins(1'b1);
         @(posedge clk);
         manual_n <= 1'b1;
         wait_rel(holds[sel], 6);
         ahb(0, ssr_pkg::OFS_CAUSE, 32'h4);
         ahb(1, ssr_pkg::OFS_CAUSE, 32'hf);
      end
      // Watchdog: idle without a falling edge, kept alive by kicks, then starved
      cyc(300);
      chk_pins(1'b0);
      @(posedge clk);
      // Kick spacing kept under 44 cycles so the starved-timeout window checks below hold
      half <= 8'(20 + $urandom_range(20));
      kick_en <= 1'b1;
      cyc(500);
      chk_pins(1'b0);
      ahb(0, ssr_pkg::OFS_STATUS, 32'h46);
      @(posedge clk);
      kick_en <= 1'b0;
      cyc(60);
      chk_pins(1'b0);
      cyc(50);
      chk_pins(1'b1);
      cyc(100);
      chk_pins(1'b0);
      ahb(0, ssr_pkg::OFS_CAUSE, 32'h8);
      // Mid-run reset: power-up cause again, hold select back to its default
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      cyc(1);
      chk_pins(1'b1);
      wait_rel(holds[2] - 1, 7);
      ahb(0, ssr_pkg::OFS_CAUSE, 32'h3);
      ahb(0, ssr_pkg::OFS_CTRL, {30'h0, ssr_pkg::CTRL_RESET});
      cyc(4);
      end_of_test();
   end
endmodule : supply_reset_supervisor_tb
